// file: verilog/flash_host_pkg.sv
// Purpose: Shared constants and types for the parallel flash host controller.
// Assumes: 100 MHz clock, word-mode flash with 20 address bits and 16 data bits.
// Notes: Command codes are package localparams with fixed values, not overridable per part.
package flash_host_pkg;

  // ****************************************
  // Widths and timing
  // ****************************************
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_NS = 20;
  localparam int STROBE_NS = 70;
  localparam int HOLD_NS = 20;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Flash command set
  // ****************************************
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 20'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 20'h002aa;
  localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00aa;
  localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_ERASE = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_CHIP = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_SECTOR = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h00f0;
  localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;

  // Status bit positions on the flash data bus
  localparam int DQ_TOGGLE = 6;
  localparam int DQ_FAIL = 5;
  localparam int DQ_WINDOW = 3;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_REJECT = 3;
  localparam int ST_READY = 4;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_SECTOR_ERASE = 3'h2,
    OP_CHIP_ERASE = 3'h3,
    OP_ADD_SECTOR = 3'h4,
    OP_RESET = 3'h5,
    OP_SUSPEND = 3'h6,
    OP_RESUME = 3'h7
  } op_e;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cyc_req_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe_n;
  } flash_pins_s;

  localparam flash_pins_s PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe_n: 1'b1};

endpackage

// file: verilog/flash_cycle.sv
// Purpose: One flash bus cycle (read or write) on the asynchronous pins.
// Assumes: Flash data bus is asynchronous to clk and is synchronised here.
// Notes: Chip select is released after every cycle so each read is distinct.
`timescale 1ns/100ps
module flash_cycle #(
  parameter int SETUP = flash_host_pkg::SETUP_CYC,
  parameter int STROBE = flash_host_pkg::STROBE_CYC,
  parameter int HOLD = flash_host_pkg::HOLD_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire flash_host_pkg::cyc_req_s req,
  output logic done,
  output logic [flash_host_pkg::DATA_W-1:0] rdata,
  output flash_host_pkg::flash_pins_s pins,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_in
);
  import flash_host_pkg::*;

  typedef enum logic [3:0] {
    E_IDLE = 4'b0001,
    E_SETUP = 4'b0010,
    E_STROBE = 4'b0100,
    E_HOLD = 4'b1000
  } eng_state_e;

  eng_state_e state_reg;
  logic [3:0] cnt_reg;
  logic wr_reg;
  logic [DATA_W-1:0] dq_meta_reg;
  logic [DATA_W-1:0] dq_sync_reg;
  wire cnt_zero = (cnt_reg == 4'h0);

  assign done = (state_reg == E_HOLD) && cnt_zero;

  // ****************************************
  // Data bus synchroniser
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dq_meta_reg <= '0;
      dq_sync_reg <= '0;
    end else begin
      dq_meta_reg <= dq_in;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  // ****************************************
  // Cycle sequencer
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= E_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      pins <= PINS_IDLE;
      rdata <= '0;
    end else begin
      unique case (state_reg)
        E_IDLE: begin
          if (start) begin
            state_reg <= E_SETUP;
            cnt_reg <= 4'(SETUP - 1);
            wr_reg <= req.wr;
            pins.addr <= req.addr;
            pins.dq_out <= req.data;
            pins.ce_n <= 1'b0;
            pins.dq_oe_n <= !req.wr;
          end
        end
        E_SETUP: begin
          if (cnt_zero) begin
            state_reg <= E_STROBE;
            cnt_reg <= 4'(STROBE - 1);
            // Write strobe only with output strobe high
            pins.we_n <= !wr_reg;
            // One output strobe per read cycle
            pins.oe_n <= wr_reg;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        E_STROBE: begin
          if (cnt_zero) begin
            state_reg <= E_HOLD;
            cnt_reg <= 4'(HOLD - 1);
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            // Sampled late so the two-stage lag still sees settled data
            rdata <= dq_sync_reg;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        E_HOLD: begin
          if (cnt_zero) begin
            state_reg <= E_IDLE;
            pins.ce_n <= 1'b1;
            pins.dq_oe_n <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_write_qualified;
    @(posedge clk) disable iff (!resetn) !pins.we_n |-> (pins.oe_n && !pins.ce_n);
  endproperty
  a_write_qualified: assert property (p_write_qualified) else $error("write strobe without qualifiers");

  property p_drive_only_writing;
    @(posedge clk) disable iff (!resetn) !pins.dq_oe_n |-> pins.oe_n;
  endproperty
  a_drive_only_writing: assert property (p_drive_only_writing) else $error("data driven during read");

  property p_read_bounded;
    @(posedge clk) disable iff (!resetn) $fell(pins.oe_n) |-> (!pins.ce_n && !pins.oe_n) [*7] ##1 pins.oe_n;
  endproperty
  a_read_bounded: assert property (p_read_bounded) else $error("read strobe width wrong");

  property p_ce_released;
    @(posedge clk) disable iff (!resetn) $rose(pins.oe_n) |-> ##[1:4] pins.ce_n;
  endproperty
  a_ce_released: assert property (p_ce_released) else $error("chip select not released after read");

  c_write_cycle: cover property (@(posedge clk) disable iff (!resetn) $fell(pins.we_n));
  c_read_cycle: cover property (@(posedge clk) disable iff (!resetn) $fell(pins.oe_n));

endmodule // flash_cycle

// file: verilog/flash_host_ctrl.sv
// Purpose: AHB-Lite controlled host that programs, erases and polls a parallel flash.
// Assumes: Single AHB-Lite slave, word transfers; flash pins asynchronous to clk.
// Notes: Completion is found with toggle-bit polling; no poll limit is applied.
//
// Operation
// - Reads delimited by output strobe or select
// - Host writes reset command after timeout failure
// - Host checks window bit around extra sectors
// - Write only with select, write low, output high
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module flash_host_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
  output logic [flash_host_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [flash_host_pkg::DATA_W-1:0] flash_dq_in,
  input wire logic ready_busy_n
);
  import flash_host_pkg::*;

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_PRECHK = 7'b0000010,
    S_SEQ = 7'b0000100,
    S_POSTCHK = 7'b0001000,
    S_POLL_A = 7'b0010000,
    S_POLL_B = 7'b0100000,
    S_RESET = 7'b1000000
  } host_state_e;

  // ****************************************
  // Command sequences
  // ****************************************
  function automatic logic [2:0] seq_last(input op_e op);
    unique case (op)
      OP_PROGRAM: seq_last = 3'd3;
      OP_SECTOR_ERASE, OP_CHIP_ERASE: seq_last = 3'd5;
      default: seq_last = 3'd0;
    endcase
  endfunction

  // Unlock pair before program and erase commands only; reset, suspend, resume and extra sector are single writes
  function automatic cyc_req_s seq_step(input op_e op, input logic [2:0] step,
                                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic erase;
    erase = (op == OP_SECTOR_ERASE) || (op == OP_CHIP_ERASE);
    seq_step = '{wr: 1'b1, addr: a, data: d};
    if (op == OP_READ) begin
      seq_step.wr = 1'b0;
    end else if (op == OP_RESET) begin
      seq_step.data = CMD_RESET;
    end else if (op == OP_SUSPEND) begin
      seq_step.data = CMD_SUSPEND;
    end else if (op == OP_RESUME) begin
      seq_step.data = CMD_RESUME;
    end else if (op == OP_ADD_SECTOR) begin
      seq_step.data = CMD_SECTOR;
    end else if (step == 3'd0 || step == 3'd3 && erase) begin
      seq_step = '{wr: 1'b1, addr: UNLOCK_ADDR1, data: UNLOCK_DATA1};
    end else if (step == 3'd1 || step == 3'd4) begin
      seq_step = '{wr: 1'b1, addr: UNLOCK_ADDR2, data: UNLOCK_DATA2};
    end else if (step == 3'd2) begin
      seq_step = '{wr: 1'b1, addr: UNLOCK_ADDR1, data: erase ? CMD_ERASE : CMD_PROGRAM};
    end else if (op == OP_CHIP_ERASE) begin
      seq_step = '{wr: 1'b1, addr: UNLOCK_ADDR1, data: CMD_CHIP};
    end else if (op == OP_SECTOR_ERASE) begin
      seq_step.data = CMD_SECTOR;
    end
  endfunction

  host_state_e state_reg;
  host_state_e state_next;
  op_e op_reg;
  logic [2:0] step_reg;
  logic pend_reg;
  logic fail_seen_reg;
  logic [DATA_W-1:0] prev_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic st_done_reg;
  logic st_fail_reg;
  logic st_reject_reg;
  logic rb_meta_reg;
  logic rb_sync_reg;
  logic ap_wr_reg;
  logic [7:0] ap_ofs_reg;
  logic eng_done;
  logic [DATA_W-1:0] eng_rdata;
  cyc_req_s eng_req;
  flash_pins_s pins;

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  wire ap_valid = hsel && htrans[1] && hready;
  wire idle = (state_reg == S_IDLE);
  wire wr_ctrl = ap_wr_reg && (ap_ofs_reg == OFS_CTRL);
  wire wr_status = ap_wr_reg && (ap_ofs_reg == OFS_STATUS);
  wire go = wr_ctrl && hwdata[CTRL_START_BIT] && idle;
  wire [31:0] status_word = {27'h0, rb_sync_reg, st_reject_reg, st_fail_reg, st_done_reg, !idle};
  wire [31:0] read_mux = (haddr[7:0] == OFS_CTRL) ? {28'h0, op_reg, 1'b0} :
                         (haddr[7:0] == OFS_ADDR) ? {12'h0, addr_reg} :
                         (haddr[7:0] == OFS_WDATA) ? {16'h0, wdata_reg} :
                         (haddr[7:0] == OFS_STATUS) ? status_word :
                         (haddr[7:0] == OFS_RDATA) ? {16'h0, rdata_reg} : 32'h0;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ap_wr_reg <= 1'b0;
      ap_ofs_reg <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      ap_wr_reg <= ap_valid && hwrite;
      ap_ofs_reg <= haddr[7:0];
      if (ap_valid && !hwrite) begin
        hrdata <= read_mux;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_reg <= OP_READ;
      addr_reg <= '0;
      wdata_reg <= '0;
    end else if (ap_wr_reg && idle) begin
      if (ap_ofs_reg == OFS_CTRL) begin
        op_reg <= op_e'(hwdata[CTRL_OP_LSB +: 3]);
      end
      if (ap_ofs_reg == OFS_ADDR) begin
        addr_reg <= hwdata[ADDR_W-1:0];
      end
      if (ap_ofs_reg == OFS_WDATA) begin
        wdata_reg <= hwdata[DATA_W-1:0];
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  wire ctrl_op_add = (op_e'(hwdata[CTRL_OP_LSB +: 3]) == OP_ADD_SECTOR);
  wire op_polls = (op_reg == OP_PROGRAM) || (op_reg == OP_SECTOR_ERASE) || (op_reg == OP_CHIP_ERASE);
  wire seq_end = (step_reg == seq_last(op_reg));
  // Two successive reads that differ in the toggle bit mean still busy
  wire toggling = (prev_reg[DQ_TOGGLE] != eng_rdata[DQ_TOGGLE]);
  // Failure bit counts only while the toggle bit still moves
  wire fail_now = toggling && eng_rdata[DQ_FAIL];
  // Window bit high around an extra sector cycle means rejection
  wire window_hit = eng_done && (state_reg == S_PRECHK || state_reg == S_POSTCHK) && eng_rdata[DQ_WINDOW];
  wire finish = eng_done && !idle && (state_next == S_IDLE);
  wire fail_set = eng_done && (state_reg == S_RESET);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: if (go) state_next = ctrl_op_add ? S_PRECHK : S_SEQ;
      S_PRECHK: if (eng_done) state_next = eng_rdata[DQ_WINDOW] ? S_IDLE : S_SEQ;
      S_SEQ: begin
        if (eng_done && seq_end) begin
          state_next = (op_reg == OP_ADD_SECTOR) ? S_POSTCHK : op_polls ? S_POLL_A : S_IDLE;
        end
      end
      S_POSTCHK: if (eng_done) state_next = S_IDLE;
      S_POLL_A: if (eng_done) state_next = S_POLL_B;
      S_POLL_B: begin
        if (eng_done) begin
          // Failure is confirmed by a second pair of reads, then a reset is written
          state_next = !toggling ? S_IDLE : (fail_now && fail_seen_reg) ? S_RESET : S_POLL_A;
        end
      end
      S_RESET: if (eng_done) state_next = S_IDLE;
    endcase
  end

  always_comb begin
    eng_req = '{wr: 1'b0, addr: addr_reg, data: '0};
    if (state_reg == S_SEQ) begin
      eng_req = seq_step(op_reg, step_reg, addr_reg, wdata_reg);
    end else if (state_reg == S_RESET) begin
      eng_req = '{wr: 1'b1, addr: addr_reg, data: CMD_RESET};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      step_reg <= 3'd0;
      pend_reg <= 1'b0;
      fail_seen_reg <= 1'b0;
      prev_reg <= '0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      pend_reg <= eng_done ? 1'b0 : (!idle || pend_reg);
      if (go) begin
        step_reg <= 3'd0;
        fail_seen_reg <= 1'b0;
      end else if (eng_done && state_reg == S_SEQ && !seq_end) begin
        step_reg <= step_reg + 3'd1;
      end
      if (eng_done && state_reg == S_POLL_A) begin
        prev_reg <= eng_rdata;
      end
      if (eng_done && state_reg == S_POLL_B && fail_now) begin
        fail_seen_reg <= 1'b1;
      end
      if (eng_done && !eng_req.wr) begin
        rdata_reg <= eng_rdata;
      end
    end
  end

  // ****************************************
  // Status and ready pin
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_done_reg <= 1'b0;
      st_fail_reg <= 1'b0;
      st_reject_reg <= 1'b0;
      rb_meta_reg <= 1'b1;
      rb_sync_reg <= 1'b1;
    end else begin
      // Hardware set wins over a software clear in the same cycle
      st_done_reg <= finish || (st_done_reg && !(wr_status && hwdata[ST_DONE]));
      st_fail_reg <= fail_set || (st_fail_reg && !(wr_status && hwdata[ST_FAIL]));
      st_reject_reg <= window_hit || (st_reject_reg && !(wr_status && hwdata[ST_REJECT]));
      // Ready/busy is only reported; the device drives it
      rb_meta_reg <= ready_busy_n;
      rb_sync_reg <= rb_meta_reg;
    end
  end

  flash_cycle u_cycle (
    .clk(clk),
    .resetn(resetn),
    .start(!idle && !pend_reg),
    .req(eng_req),
    .done(eng_done),
    .rdata(eng_rdata),
    .pins(pins),
    .dq_in(flash_dq_in)
  );

  assign flash_ce_n = pins.ce_n;
  assign flash_oe_n = pins.oe_n;
  assign flash_we_n = pins.we_n;
  assign flash_addr = pins.addr;
  assign flash_dq_out = pins.dq_out;
  assign flash_dq_oe_n = pins.dq_oe_n;

  // ****************************************
  // Assertions
  // ****************************************
  property p_fail_after_reset;
    @(posedge clk) disable iff (!resetn) $rose(st_fail_reg) |-> $past(state_reg == S_RESET) && $past(eng_done);
  endproperty
  a_fail_after_reset: assert property (p_fail_after_reset) else $error("failure flagged without reset write");

  property p_reset_cmd_data;
    @(posedge clk) disable iff (!resetn) (state_reg == S_RESET) && !flash_we_n |-> flash_dq_out == CMD_RESET;
  endproperty
  a_reset_cmd_data: assert property (p_reset_cmd_data) else $error("reset write carries wrong data");

  property p_reject_cause;
    @(posedge clk) disable iff (!resetn) $rose(st_reject_reg) |-> $past(eng_rdata[DQ_WINDOW]) &&
      ($past(state_reg == S_PRECHK) || $past(state_reg == S_POSTCHK));
  endproperty
  a_reject_cause: assert property (p_reject_cause) else $error("reject without window bit");

  property p_precheck_blocks;
    @(posedge clk) disable iff (!resetn) (state_reg == S_PRECHK) && eng_done && eng_rdata[DQ_WINDOW] |=> idle;
  endproperty
  a_precheck_blocks: assert property (p_precheck_blocks) else $error("sector cycle sent after window closed");

  c_program_done: cover property (@(posedge clk) disable iff (!resetn) finish && op_reg == OP_PROGRAM);
  c_fail_path: cover property (@(posedge clk) disable iff (!resetn) fail_set);
  c_reject: cover property (@(posedge clk) disable iff (!resetn) window_hit);

endmodule // flash_host_ctrl

// file: testbench/flash_dev_model.sv
// Purpose: Behavioural parallel flash seen by the host controller.
// Assumes: 256-word array, sectors of 16 words, one protected sector.
// Notes: Busy time is a count of status reads, so runs stay short.
`timescale 1ns/100ps
module flash_dev_model #(
  parameter int BUSY_READS = 6,
  parameter logic [19:0] PROT_ADDR = 20'h00040
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_in,
  input wire logic supply_low,
  output logic [15:0] dq_out,
  output logic ready_busy_n
);
  import flash_host_pkg::*;
  logic [15:0] mem [0:255];
  logic [15:0] pd, last;
  logic [7:0] pa, ea;
  logic [2:0] seq;
  logic [1:0] mode;
  logic tog, tog2, fail, win, chip, up;
  int left;
  wire rd_n = ce_n | oe_n;
  wire busy = mode == 2'h1 || mode == 2'h2;
  wire in_sec = mode[1] && addr[7:4] == ea[7:4];
  wire [15:0] stat = {8'h00, mode == 2'h1 ? ~pd[7] : mode == 2'h3, tog, fail, 1'b0, win, tog2, 2'h0};
  wire [15:0] val = (busy || (mode == 2'h3 && in_sec)) ? stat : mem[addr[7:0]];
  // Released bus shows the inverse of the last value, never a held copy
  assign dq_out = rd_n ? ~last : val;
  assign ready_busy_n = !busy;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
    {seq, mode, tog, tog2, fail, win, chip, up, last} = '0;
    left = 0;
    #50 up = 1'b1;
  end
  // ****************************************
  // Read and write cycles
  // ****************************************
  always @(negedge rd_n) begin
    if (in_sec) tog2 = ~tog2;
    if (busy) begin
      tog = ~tog;
      left = left - 1;
      if (left < BUSY_READS - 2) win = 1'b1;
      if (left <= 0 && !fail) begin
        if (mode == 2'h1 && pa[7:4] != PROT_ADDR[7:4]) mem[pa] = mem[pa] & pd;
        if (mode == 2'h2) begin
          for (int i = 0; i < 256; i++)
            if ((chip || i[7:4] == ea[7:4]) && i[7:4] != PROT_ADDR[7:4]) mem[i] = 16'hffff;
        end
        mode = 2'h0;
      end
    end
  end
  always @(posedge rd_n) last = val;
  // Low supply drops any command in flight and forces read mode
  always @(posedge supply_low) {seq, mode, fail} = '0;
  always @(posedge we_n) begin
    if (!ce_n && oe_n && up && !supply_low) begin
      if (dq_in == CMD_RESET && (!busy || fail)) begin
        mode = 2'h0;
        fail = 1'b0;
        seq = 3'h0;
      end else if (mode[1]) begin
        if (dq_in == CMD_SUSPEND && mode == 2'h2) mode = 2'h3;
        else if (dq_in == CMD_RESUME && mode == 2'h3) mode = 2'h2;
        else if (dq_in == CMD_SECTOR && !win) left = left + 2;
      end else begin
        case (seq)
          3'h0: seq = (addr == UNLOCK_ADDR1 && dq_in == UNLOCK_DATA1) ? 3'h1 : 3'h0;
          3'h1: seq = (addr == UNLOCK_ADDR2 && dq_in == UNLOCK_DATA2) ? 3'h2 : 3'h0;
          3'h2: seq = dq_in == CMD_PROGRAM ? 3'h3 : dq_in == CMD_ERASE ? 3'h4 : 3'h0;
          3'h3: begin
            pa = addr[7:0];
            pd = dq_in;
            fail = |(dq_in & ~mem[addr[7:0]]);
            mode = 2'h1;
            left = BUSY_READS;
            seq = 3'h0;
          end
          3'h4: seq = (addr == UNLOCK_ADDR1 && dq_in == UNLOCK_DATA1) ? 3'h5 : 3'h0;
          3'h5: seq = (addr == UNLOCK_ADDR2 && dq_in == UNLOCK_DATA2) ? 3'h6 : 3'h0;
          default: begin
            ea = addr[7:0];
            chip = dq_in == CMD_CHIP;
            win = chip;
            mode = (chip || dq_in == CMD_SECTOR) ? 2'h2 : 2'h0;
            left = BUSY_READS;
            seq = 3'h0;
          end
        endcase
      end
    end
  end
endmodule // flash_dev_model

// file: testbench/flash_write_status_and_protect_bench.sv
// Purpose: Self-checking bench for the AHB-Lite flash host controller.
// Assumes: Zero wait-state slave; flash model busy for fixed read counts.
// Notes: Ready bit is masked in op checks since it crosses two flops late.
`timescale 1ns/100ps
module flash_write_status_and_protect_bench;
  import flash_host_pkg::*;
  localparam logic [19:0] PROT = 20'h00040;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic supply_low = 1'b0;
  logic hreadyout, hresp, ce_n, oe_n, we_n, dq_oe_n, rb_n;
  logic [31:0] hrdata, rd;
  logic [19:0] faddr;
  logic [15:0] dq_o, dev_dq;
  wire [15:0] dq_in = dq_oe_n ? dev_dq : dq_o;
  int err_total = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  flash_host_ctrl u_flash_host_ctrl (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(faddr),
    .flash_dq_out(dq_o), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in), .ready_busy_n(rb_n));
  flash_dev_model #(.PROT_ADDR(PROT)) u_flash_dev_model (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(faddr),
    .dq_in(dq_in), .supply_low(supply_low), .dq_out(dev_dq), .ready_busy_n(rb_n));
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic rdreg(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, '0);
    chk(rd, exp);
  endtask
  task automatic op(input op_e o, input logic [19:0] a, input logic [15:0] d, input logic [31:0] exp);
    int n = 0;
    ahb(1'b1, OFS_ADDR, {12'h0, a});
    ahb(1'b1, OFS_WDATA, {16'h0, d});
    ahb(1'b1, OFS_CTRL, {28'h0, o, 1'b1});
    rd = '0;
    while (rd[ST_DONE] !== 1'b1 && n < 2000) begin
      ahb(1'b0, OFS_STATUS, '0);
      n++;
    end
    chk(rd & 32'hf, exp);
    ahb(1'b1, OFS_STATUS, 32'he);
  endtask
  task automatic frd(input logic [19:0] a, input logic [15:0] v);
    op(OP_READ, a, 16'h0, 32'h2);
    rdreg(OFS_RDATA, {16'h0, v});
  endtask
  task automatic finish_test;
    $display("counts: tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // Checks and sequence
  // ****************************************
  always @(posedge clk) begin
    if (resetn && ((!we_n && (!oe_n || ce_n)) || hresp !== 1'b0)) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, {hresp, we_n, oe_n, ce_n}, 4'h1);
    end
  end
  initial begin
    #500000;
    err_total++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdreg(OFS_STATUS, 32'h10);
    rdreg(8'h20, 32'h0);
    $display("test reset done");
    op(OP_PROGRAM, 20'h10, 16'h1234, 32'h2);
    frd(20'h10, 16'h1234);
    op(OP_ADD_SECTOR, 20'h10, 16'h0, 32'h2);
    op(OP_PROGRAM, 20'h10, 16'h00ff, 32'h6);
    frd(20'h10, 16'h1234);
    op(OP_PROGRAM, PROT, 16'h0000, 32'h2);
    frd(PROT, 16'hffff);
    $display("test program done");
    op(OP_SECTOR_ERASE, 20'h10, 16'h0, 32'h2);
    frd(20'h10, 16'hffff);
    op(OP_ADD_SECTOR, 20'h20, 16'h0, 32'ha);
    rdreg(OFS_STATUS, 32'h10);
    for (int k = 5; k < 8; k++) op(op_e'(k), 20'h30, 16'h0, 32'h2);
    op(OP_PROGRAM, 20'h30, 16'h5678, 32'h2);
    op(OP_CHIP_ERASE, 20'h0, 16'h0, 32'h2);
    frd(20'h30, 16'hffff);
    supply_low <= 1'b1;
    op(OP_PROGRAM, 20'h50, 16'h0, 32'h2);
    supply_low <= 1'b0;
    frd(20'h50, 16'hffff);
    $display("test erase done");
    ahb(1'b1, OFS_ADDR, 32'h50);
    ahb(1'b1, OFS_CTRL, {28'h0, OP_READ, 1'b1});
    ahb(1'b1, OFS_ADDR, 32'h60);
    rdreg(OFS_ADDR, 32'h50);
    repeat (20) @(posedge clk);
    rdreg(OFS_RDATA, 32'hffff);
    $display("test busy done");
    finish_test;
  end
endmodule // flash_write_status_and_protect_bench
